// ==== rtl/exec_core_pkg.sv ====
// constants, formats and types for the branch/skip/bit/shift core
package exec_core_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int PC_W   = 16;
  localparam int NREGS  = 32;
  localparam int NIO    = 32;
  localparam int WAIT_W = 2;
  localparam int DEPTH  = 16;
  // ----------------------------------------
  // major opcodes, bits 15:12
  // ----------------------------------------
  localparam logic [3:0] OP_MISC   = 4'h0;
  localparam logic [3:0] OP_CMP    = 4'h1;
  localparam logic [3:0] OP_CMPI   = 4'h2;
  localparam logic [3:0] OP_REL_JUMP = 4'h3;
  localparam logic [3:0] OP_REL_CALL = 4'h4;
  localparam logic [3:0] OP_BRANCH = 4'h5;
  localparam logic [3:0] OP_SKREG  = 4'h6;
  localparam logic [3:0] OP_SKIO   = 4'h7;
  localparam logic [3:0] OP_IOBIT  = 4'h8;
  localparam logic [3:0] OP_SHIFT  = 4'h9;
  localparam logic [3:0] OP_LONG   = 4'hf;
  // misc sub-codes
  localparam logic [3:0] MI_JUMP_Z     = 4'h1;
  localparam logic [3:0] MI_CALL_Z     = 4'h2;
  localparam logic [3:0] MI_RETURN     = 4'h3;
  localparam logic [3:0] MI_RETURN_IRQ = 4'h4;
  // compare sub-codes
  localparam logic [1:0] CM_SKIP  = 2'h0;
  localparam logic [1:0] CM_REGS  = 2'h1;
  localparam logic [1:0] CM_CARRY = 2'h2;
  // shift kinds
  localparam logic [1:0] SH_LEFT      = 2'h0;
  localparam logic [1:0] SH_RIGHT     = 2'h1;
  localparam logic [1:0] SH_ROT_LEFT  = 2'h2;
  localparam logic [1:0] SH_ROT_RIGHT = 2'h3;
  // ----------------------------------------
  // status flag positions
  // ----------------------------------------
  localparam int F_C = 0;
  localparam int F_Z = 1;
  localparam int F_N = 2;
  localparam int F_V = 3;
  localparam int F_S = 4;
  localparam int F_H = 5;
  localparam int F_T = 6;
  localparam int F_I = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // ----------------------------------------
  // pointers and cycle counts
  // ----------------------------------------
  localparam int Z_LO = 30;
  localparam int Z_HI = 31;
  localparam logic IMM_BASE = 1'b1;
  localparam logic [WAIT_W-1:0] CY_BR   = 2'd2;
  localparam logic [WAIT_W-1:0] CY_JMP  = 2'd2;
  localparam logic [WAIT_W-1:0] CY_CALL = 2'd3;
  localparam logic [WAIT_W-1:0] CY_RETURN = 2'd3;
  localparam logic [WAIT_W-1:0] CY_IOB  = 2'd2;
  localparam logic [WAIT_W-1:0] CY_LONG = 2'd2;
  // preload targets
  localparam logic [1:0] TG_REG  = 2'h0;
  localparam logic [1:0] TG_IO   = 2'h1;
  localparam logic [1:0] TG_FLAG = 2'h2;
  // ----------------------------------------
  // instruction formats
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] op; logic [1:0] sub;
    logic [4:0] rd; logic [4:0] rr;
  } fmt_rr_t;
  typedef struct packed {
    logic [3:0] op; logic [3:0] rd; logic [7:0] k;
  } fmt_imm_t;
  typedef struct packed {
    logic [3:0] op; logic pol;
    logic [2:0] flag; logic [7:0] k;
  } fmt_br_t;
  typedef struct packed {
    logic [3:0] op; logic pol; logic [2:0] pad;
    logic [4:0] sel; logic [2:0] bitn;
  } fmt_bit_t;
  typedef struct packed {
    logic [3:0] op; logic [1:0] kind;
    logic [4:0] pad; logic [4:0] rd;
  } fmt_sh_t;
  // preload port bundle
  typedef struct packed {
    logic valid; logic [1:0] tgt;
    logic [4:0] addr; logic [7:0] data;
  } load_t;
endpackage

// ==== rtl/exec_core.sv ====
// execution core for compare, skip, branch, bit and shift groups
`timescale 1ns/1ps
// Overview of operation
// RULE1 - equal registers skip next word, no flags
// RULE2 - register bit clear/set skips next word
// RULE3 - I/O bit clear/set skips next word
// RULE4 - compares set Z N V C H, and S as N xor V
// RULE5 - flag branch loads pc plus k plus one
// RULE6 - signed branches test N xor V
// RULE7 - unsigned and carry branches test C
// RULE8 - half carry branches test H
// RULE9 - transfer branches test T
// RULE10 - overflow branches test V
// RULE11 - interrupt branches test I
// RULE12 - indirect jump loads Z in two cycles
// RULE13 - indirect call pushes, loads Z, three cycles
// RULE14 - set or clear one I/O bit, two cycles
// RULE15 - left shift, zero in, carry old bit7
// RULE16 - right shift, zero in, carry old bit0
// RULE17 - rotate left through carry
// RULE18 - rotate right through carry
// RULE19 - relative jump/call, two/three cycles
// RULE20 - returns pop pc in four cycles
module exec_core
  import exec_core_pkg::*;
#(
  parameter int STACK_DEPTH = DEPTH
)(
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire logic                 run,
  input  wire logic [15:0]          prog_word,
  input  wire load_t                preload,
  output logic [PC_W-1:0]           prog_addr,
  output logic [7:0]                status_flags_register,
  output logic [NREGS-1:0][7:0]     work_regs,
  output logic [NIO-1:0][7:0]       io_space,
  output logic                      busy
);
  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  localparam int SP_W = $clog2(STACK_DEPTH);
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH)
  begin : g_bad_depth
    $error("stack depth must be a power of 2");
  end
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_EXEC,
    ST_SKIP,
    ST_WAIT
  } state_t;
  state_t              state;      // sequencer
  state_t              next_state; // its next value
  logic [WAIT_W-1:0]   wait_cnt;   // extra cycles left
  logic [WAIT_W-1:0]   next_wait;  // next wait count
  logic [PC_W-1:0]     next_pc;    // next program counter
  logic [7:0]          next_flags; // next status flags
  logic [PC_W-1:0]     stack_mem [STACK_DEPTH];
  logic [SP_W-1:0]     sp;         // next free slot
  logic                do_push;    // write return address
  logic                do_pop;     // drop top entry
  logic                wr_reg;     // shift writes rd
  logic                wr_io;      // bit op writes io
  // ----------------------------------------
  // instruction views
  // ----------------------------------------
  fmt_rr_t  f_rr;   // register pair form
  fmt_imm_t f_imm;  // immediate form
  fmt_br_t  f_br;   // flag branch form
  fmt_bit_t f_bit;  // bit select form
  fmt_sh_t  f_sh;   // shift form
  assign f_rr  = fmt_rr_t'(prog_word);
  assign f_imm = fmt_imm_t'(prog_word);
  assign f_br  = fmt_br_t'(prog_word);
  assign f_bit = fmt_bit_t'(prog_word);
  assign f_sh  = fmt_sh_t'(prog_word);
  wire [3:0] op  = f_rr.op;
  wire [3:0] sub = prog_word[11:8];
  // ----------------------------------------
  // operands
  // ----------------------------------------
  wire [4:0] imm_reg = {IMM_BASE, f_imm.rd};
  wire       is_imm  = (op == OP_CMPI);
  // first operand register
  wire [7:0] opa = is_imm ? work_regs[imm_reg] : work_regs[f_rr.rd];
  // second operand, register or constant
  wire [7:0] opb = is_imm ? f_imm.k : work_regs[f_rr.rr];
  // carry into subtraction for carry form
  wire       use_c = (op == OP_CMP) && (f_rr.sub == CM_CARRY);
  wire       cin   = use_c & status_flags_register[F_C];
  // ----------------------------------------
  // compare arithmetic
  // ----------------------------------------
  wire [8:0] diff = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
  wire [7:0] res  = diff[7:0];
  // borrow out of bit 3
  wire h_cmp = (~opa[3] & opb[3]) | (opb[3] & res[3]) | (res[3] & ~opa[3]);
  // signed overflow
  wire v_cmp = (opa[7] & ~opb[7] & ~res[7]) | (~opa[7] & opb[7] & res[7]);
  // borrow out of bit 7
  wire c_cmp = (~opa[7] & opb[7]) | (opb[7] & res[7]) | (res[7] & ~opa[7]);
  // carry form keeps a zero chain
  wire z_raw = (res == 8'h00);
  wire z_cmp = use_c ? (z_raw & status_flags_register[F_Z]) : z_raw;
  // ----------------------------------------
  // shift unit
  // ----------------------------------------
  wire [7:0] sh_in = work_regs[f_sh.rd];
  wire       c_old = status_flags_register[F_C];
  logic [7:0] sh_res; // shifted value
  logic       sh_c;   // carry out
  always_comb
  begin
    sh_res = sh_in;
    sh_c   = 1'b0;
    case (f_sh.kind)
      SH_LEFT:      {sh_c, sh_res} = {sh_in, 1'b0};  // RULE15
      SH_RIGHT:     {sh_res, sh_c} = {1'b0, sh_in};  // RULE16
      SH_ROT_LEFT:  {sh_c, sh_res} = {sh_in, c_old}; // RULE17
      SH_ROT_RIGHT: {sh_res, sh_c} = {c_old, sh_in}; // RULE18
      default:      {sh_c, sh_res} = {1'b0, sh_in};
    endcase
  end
  wire sh_n = sh_res[7];
  wire sh_v = sh_n ^ sh_c;
  // ----------------------------------------
  // branch and skip conditions
  // ----------------------------------------
  // sign slot always read live as N xor V
  wire [7:0] fl = status_flags_register;
  wire [7:0] fview = {fl[7:5], fl[F_N] ^ fl[F_V], fl[3:0]}; // RULE6
  // any flag, either polarity
  wire br_take = (fview[f_br.flag] == f_br.pol); // RULE5 RULE7 RULE8 RULE9 RULE10 RULE11
  wire sk_eq  = (work_regs[f_rr.rd] == work_regs[f_rr.rr]);       // RULE1
  wire sk_reg = (work_regs[f_bit.sel][f_bit.bitn] == f_bit.pol); // RULE2
  wire sk_io  = (io_space[f_bit.sel][f_bit.bitn] == f_bit.pol);  // RULE3
  // ----------------------------------------
  // targets
  // ----------------------------------------
  wire [PC_W-1:0] pc1  = prog_addr + 16'h0001;
  wire [PC_W-1:0] pc2  = prog_addr + 16'h0002;
  wire [PC_W-1:0] k8   = {{8{f_br.k[7]}}, f_br.k};
  wire [PC_W-1:0] k12  = {{4{prog_word[11]}}, prog_word[11:0]};
  wire [PC_W-1:0] br_t = pc1 + k8;  // RULE5
  wire [PC_W-1:0] rl_t = pc1 + k12; // RULE19
  wire [PC_W-1:0] zptr = {work_regs[Z_HI], work_regs[Z_LO]};
  wire [SP_W-1:0] sp_dn = sp - 1'b1;
  wire [PC_W-1:0] top  = stack_mem[sp_dn];
  // io bit value after set or clear
  logic [7:0] io_new;
  always_comb
  begin
    io_new = io_space[f_bit.sel];
    io_new[f_bit.bitn] = f_bit.pol; // RULE14
  end
  // preload hits the flags
  wire ld_fl = preload.valid && (preload.tgt == TG_FLAG);
  wire [7:0] base_fl = ld_fl ? preload.data : fl;
  // ----------------------------------------
  // sequencer decode
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_wait  = wait_cnt;
    next_pc    = prog_addr;
    next_flags = base_fl;
    do_push    = 1'b0;
    do_pop     = 1'b0;
    wr_reg     = 1'b0;
    wr_io      = 1'b0;
    case (state)
      ST_EXEC:
      begin
        if (run)
        begin
          next_pc   = pc1;
          next_wait = '0;
          case (op)
            OP_MISC:
            begin
              case (sub)
                MI_JUMP_Z:
                begin
                  next_pc   = zptr;            // RULE12
                  next_wait = CY_JMP - 2'd1;   // RULE12
                end
                MI_CALL_Z:
                begin
                  do_push   = 1'b1;            // RULE13
                  next_pc   = zptr;            // RULE13
                  next_wait = CY_CALL - 2'd1;  // RULE13
                end
                MI_RETURN, MI_RETURN_IRQ:
                begin
                  do_pop    = 1'b1;            // RULE20
                  next_pc   = top;             // RULE20
                  next_wait = CY_RETURN;       // RULE20
                  if (sub == MI_RETURN_IRQ) next_flags[F_I] = 1'b1; // RULE20
                end
                default: next_pc = pc1; // no operation
              endcase
            end
            OP_CMP, OP_CMPI:
            begin
              if (op == OP_CMP && f_rr.sub == CM_SKIP)
              begin
                if (sk_eq) next_state = ST_SKIP; // RULE1
              end
              else
              begin
                next_flags[F_Z] = z_cmp;   // RULE4
                next_flags[F_N] = res[7];  // RULE4
                next_flags[F_V] = v_cmp;   // RULE4
                next_flags[F_C] = c_cmp;   // RULE4
                next_flags[F_H] = h_cmp;   // RULE4
                next_flags[F_S] = res[7] ^ v_cmp;
              end
            end
            OP_REL_JUMP:
            begin
              next_pc   = rl_t;           // RULE19
              next_wait = CY_JMP - 2'd1;  // RULE19
            end
            OP_REL_CALL:
            begin
              do_push   = 1'b1;           // RULE19
              next_pc   = rl_t;           // RULE19
              next_wait = CY_CALL - 2'd1; // RULE19
            end
            OP_BRANCH:
            begin
              if (br_take)
              begin
                next_pc   = br_t;           // RULE5
                next_wait = CY_BR - 2'd1;   // RULE5
              end
            end
            OP_SKREG: if (sk_reg) next_state = ST_SKIP; // RULE2
            OP_SKIO:  if (sk_io) next_state = ST_SKIP;  // RULE3
            OP_IOBIT:
            begin
              wr_io     = 1'b1;           // RULE14
              next_wait = CY_IOB - 2'd1;  // RULE14
            end
            OP_SHIFT:
            begin
              wr_reg = 1'b1;
              next_flags[F_Z] = (sh_res == 8'h00);
              next_flags[F_N] = sh_n;
              next_flags[F_V] = sh_v;
              next_flags[F_C] = sh_c;
              next_flags[F_S] = sh_n ^ sh_v;
            end
            OP_LONG:
            begin
              next_pc   = pc2; // two-word no-op
              next_wait = CY_LONG - 2'd1;
            end
            default: next_pc = pc1; // unused codes idle
          endcase
          if (next_wait != '0) next_state = ST_WAIT;
        end
      end
      ST_SKIP:
      begin
        // skipped word is on prog_word now
        if (op == OP_LONG)
        begin
          next_pc    = pc2;       // RULE1 RULE2 RULE3
          next_wait  = 2'd1;
          next_state = ST_WAIT;
        end
        else
        begin
          next_pc    = pc1;       // RULE1 RULE2 RULE3
          next_state = ST_EXEC;
        end
      end
      ST_WAIT:
      begin
        next_wait = wait_cnt - 2'd1;
        if (wait_cnt == 2'd1) next_state = ST_EXEC;
      end
      default: next_state = ST_EXEC;
    endcase
  end
  // ----------------------------------------
  // sequencer registers
  // ----------------------------------------
  // pc, flags, wait count and state
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state                 <= ST_EXEC;
      wait_cnt              <= '0;
      prog_addr             <= 16'h0000;
      status_flags_register <= FLAGS_RST;
      busy                  <= 1'b0;
    end
    else
    begin
      state                 <= next_state;
      wait_cnt              <= next_wait;
      prog_addr             <= next_pc;
      status_flags_register <= next_flags;
      busy                  <= (next_state != ST_EXEC);
    end
  end
  // ----------------------------------------
  // return stack
  // ----------------------------------------
  // pointer wraps on overflow
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      sp <= '0;
    else if (do_push)
      sp <= sp + 1'b1;
    else if (do_pop)
      sp <= sp_dn;
  end
  // return address store, no reset
  always_ff @(posedge clk_sys)
  begin
    if (do_push) stack_mem[sp] <= pc1; // RULE13 RULE19
  end
  // ----------------------------------------
  // working and io registers
  // ----------------------------------------
  // execution write beats a preload
  for (genvar i = 0; i < NREGS; i++)
  begin : g_regs
    wire ex_reg = wr_reg && (f_sh.rd == i);
    wire ex_io  = wr_io && (f_bit.sel == i);
    wire ld_hit = preload.valid && (preload.addr == i);
    always_ff @(posedge clk_sys)
    begin
      if (!reset_n)
      begin
        work_regs[i] <= 8'h00;
        io_space[i]  <= 8'h00;
      end
      else
      begin
        if (ex_reg) work_regs[i] <= sh_res;
        else if (ld_hit && preload.tgt == TG_REG) work_regs[i] <= preload.data;
        if (ex_io) io_space[i] <= io_new; // RULE14
        else if (ld_hit && preload.tgt == TG_IO) io_space[i] <= preload.data;
      end
    end
  end
endmodule // exec_core

// ==== testbench/prog_rom.sv ====
// program memory model answering the core's fetch address
`timescale 1ns/1ps
module prog_rom
  import exec_core_pkg::*;
(
  input  wire logic [PC_W-1:0] prog_addr, // fetch address from the core
  output logic [15:0]          prog_word  // word at that address
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] mem [0:65535]; // word array, bench fills it

  // empty words decode as one-cycle no-ops
  initial
  begin
    for (int i = 0; i < 65536; i++) mem[i] = 16'h0000;
  end

  // same-cycle read, as the core expects
  assign prog_word = mem[prog_addr];
endmodule // prog_rom

// ==== testbench/exec_core_props.sv ====
// concurrent checks on the execution core ports
`timescale 1ns/1ps
module exec_core_props
  import exec_core_pkg::*;
#(
  parameter int STACK_DEPTH = DEPTH
)(
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             run,
  input  wire logic [15:0]      prog_word,
  input  wire load_t            preload,
  input  wire logic [PC_W-1:0]  prog_addr,
  input  wire logic [7:0]       status_flags_register,
  input  wire logic [NREGS-1:0][7:0] work_regs,
  input  wire logic [NIO-1:0][7:0]   io_space,
  input  wire logic             busy
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  wire logic       start  = run && !busy;       // new instruction taken
  wire logic [3:0] op     = prog_word[15:12];  // major opcode
  wire logic [3:0] sub    = prog_word[11:8];   // misc sub-code
  wire logic [2:0] fsel   = prog_word[10:8];   // branch flag select
  wire logic       fval   = (fsel == 3'd4) ?
    (status_flags_register[F_N] ^ status_flags_register[F_V]) :
    status_flags_register[fsel];
  wire logic       br_go  = start && op == OP_BRANCH && fval == prog_word[11];
  wire logic       br_no  = start && op == OP_BRANCH && fval != prog_word[11];
  wire logic [15:0] br_tgt = prog_addr + {{8{prog_word[7]}}, prog_word[7:0]} + 16'h0001;
  wire logic [15:0] z_ptr  = {work_regs[Z_HI], work_regs[Z_LO]};
  wire logic       sk_hit = work_regs[prog_word[7:3]][prog_word[2:0]] == prog_word[11];
  wire logic [7:0] rd_val = work_regs[prog_word[4:0]]; // shift operand

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // wait-cycle shapes
  // ----------------------------------------
  sequence s_w1; busy ##1 !busy; endsequence
  sequence s_w2; busy [*2] ##1 !busy; endsequence
  sequence s_w3; busy [*3] ##1 !busy; endsequence

  AST_SKIP_REG: assert property (start && op == OP_SKREG |=> busy == $past(sk_hit)
    && prog_addr == $past(prog_addr) + 16'h0001 && $stable(status_flags_register))
    else $error("register bit skip wrong");
  AST_CMP_ONE: assert property (start && op == OP_CMP && prog_word[11:10] != CM_SKIP
    |=> !busy && prog_addr == $past(prog_addr) + 16'h0001 && $stable(work_regs))
    else $error("compare not single cycle");
  AST_BR_TAKEN: assert property (br_go |=> (prog_addr == $past(br_tgt) && busy)
    ##1 (!busy && $stable(prog_addr)))
    else $error("taken branch wrong");
  AST_BR_NOT: assert property (br_no |=> !busy
    && prog_addr == $past(prog_addr) + 16'h0001 && $stable(status_flags_register))
    else $error("untaken branch wrong");
  AST_JUMP_Z: assert property (start && op == OP_MISC && sub == MI_JUMP_Z
    |=> (prog_addr == $past(z_ptr)) ##0 s_w1)
    else $error("indirect jump wrong");
  AST_CALL_Z: assert property (start && op == OP_MISC && sub == MI_CALL_Z
    |=> (prog_addr == $past(z_ptr)) ##0 s_w2)
    else $error("indirect call wrong");
  AST_REL_CALL: assert property (start && op == OP_REL_CALL |=> s_w2)
    else $error("relative call length wrong");
  AST_RETURN: assert property (start && op == OP_MISC && (sub == MI_RETURN || sub == MI_RETURN_IRQ)
    |=> s_w3)
    else $error("return length wrong");
  AST_IOBIT: assert property (start && op == OP_IOBIT |=>
    (io_space[$past(prog_word[7:3])][$past(prog_word[2:0])] == $past(prog_word[11])
    && $stable(status_flags_register)) ##0 s_w1)
    else $error("io bit write wrong");
  AST_SHIFT_RIGHT: assert property (start && op == OP_SHIFT && prog_word[11:10] == SH_RIGHT
    |=> work_regs[$past(prog_word[4:0])] == {1'b0, $past(rd_val[7:1])}
    && status_flags_register[F_C] == $past(rd_val[0]))
    else $error("right shift wrong");
  AST_ROT_LEFT: assert property (start && op == OP_SHIFT && prog_word[11:10] == SH_ROT_LEFT
    |=> work_regs[$past(prog_word[4:0])] == {$past(rd_val[6:0]),
    $past(status_flags_register[F_C])} && status_flags_register[F_C] == $past(rd_val[7]))
    else $error("rotate left wrong");
endmodule // exec_core_props

bind exec_core exec_core_props #(.STACK_DEPTH(STACK_DEPTH)) u_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .run(run), .prog_word(prog_word),
  .preload(preload), .prog_addr(prog_addr),
  .status_flags_register(status_flags_register), .work_regs(work_regs),
  .io_space(io_space), .busy(busy));

// ==== testbench/test_branch_skip_bit_shift_exec.sv ====
// self-checking bench for the execution core
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module test_branch_skip_bit_shift_exec
  import exec_core_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                     clk_sys, reset_n, run; // clock, reset, go
  load_t                    preload;               // state preload
  logic [15:0]              prog_word, prog_addr;  // fetch path
  logic [7:0]               flags;                 // status flags
  logic [NREGS-1:0][7:0]    regs;                  // working registers
  logic [NIO-1:0][7:0]      ios;                   // io registers
  logic                     busy;                  // extra cycles
  int                       mismatches, tests_run, cyc;

  exec_core uut (.clk_sys(clk_sys), .reset_n(reset_n), .run(run), .prog_word(prog_word),
    .preload(preload), .prog_addr(prog_addr), .status_flags_register(flags),
    .work_regs(regs), .io_space(ios), .busy(busy));
  prog_rom rom (.prog_addr(prog_addr), .prog_word(prog_word));

  // 25 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      final_report;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // reset for n cycles, wipe low memory
  task rst(input int n);
    reset_n = 1'b0;
    run = 1'b0;
    preload = '0;
    for (int i = 0; i < 8; i++) rom.mem[i] = 16'h0000;
    repeat (n) @(posedge clk_sys);
    #1 reset_n = 1'b1;
  endtask

  // one-cycle preload write
  task pl(input logic [1:0] t, input logic [4:0] a, input logic [7:0] d);
    preload = '{1'b1, t, a, d};
    @(posedge clk_sys);
    #1 preload.valid = 1'b0;
  endtask

  // run until pc reaches e in EXEC, count edges
  task go(input logic [15:0] e, input int c);
    int n;
    n = 0;
    run = 1'b1;
    do
    begin
      @(posedge clk_sys);
      #1 n++;
    end while (!(prog_addr === e && busy === 1'b0) && n < 40);
    run = 1'b0;
    `CHK("pc", e, prog_addr)
    `CHK("cycles", c, n)
  endtask

  // ----------------------------------------
  // stimulus tables
  // ----------------------------------------
  logic [15:0] sk_w [6] = '{{OP_CMP, CM_SKIP, 5'd1, 5'd2}, {OP_CMP, CM_SKIP, 5'd1, 5'd3},
    {OP_SKREG, 4'h0, 5'd1, 3'd0}, {OP_SKREG, 4'h8, 5'd1, 3'd0},
    {OP_SKIO, 4'h0, 5'd5, 3'd2}, {OP_SKIO, 4'h8, 5'd5, 3'd2}};
  bit          sk_hit [6] = '{1, 0, 1, 0, 0, 1};
  logic [7:0]  fv [3] = '{8'h2c, 8'hd3, 8'h04}; // flag patterns
  logic [15:0] fw0 [5] = '{{OP_REL_JUMP, 12'h800}, {OP_MISC, MI_JUMP_Z, 8'h00},
    {OP_MISC, MI_CALL_Z, 8'h00}, {OP_REL_CALL, 12'h004}, {OP_REL_CALL, 12'h004}};
  logic [15:0] fa1 [5] = '{16'h0002, 16'h0002, 16'h1234, 16'h0005, 16'h0005};
  logic [15:0] fw1 [5] = '{16'h0000, 16'h0000, {OP_MISC, MI_RETURN, 8'h00},
    {OP_MISC, MI_RETURN, 8'h00}, {OP_MISC, MI_RETURN_IRQ, 8'h00}};
  logic [15:0] fend [5] = '{16'hf801, 16'h1234, 16'h0001, 16'h0001, 16'h0001};
  int          fcy [5] = '{2, 2, 7, 7, 7};
  logic [7:0]  ffl [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
  int          kd [11] = '{0, 0, 0, 0, 1, 1, 2, 3, 4, 5, 6}; // compare kinds, then shifts
  logic [7:0]  ca [11] = '{8'h10, 8'h10, 8'h80, 8'h01, 8'h11, 8'h11, 8'h10,
    8'h81, 8'h81, 8'h81, 8'h01};
  logic [7:0]  cb [11] = '{8'h10, 8'h01, 8'h01, 8'h02, 8'h10, 8'h10, 8'h20,
    8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  cf [11] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h43, 8'h41, 8'h40,
    8'h60, 8'h40, 8'h41, 8'h01};

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic       fl, cin, c;
    logic [8:0] d;
    logic [4:0] hd;
    logic [7:0] ef, m, er, r;
    reset_n = 1'b0;
    run = 1'b0;
    preload = '0;
    rst(8);
    // skips over short and long words
    for (int i = 0; i < 6; i++)
      for (int j = 0; j < 2; j++)
      begin
        rst(2);
        pl(TG_REG, 5'd1, 8'h5a);
        pl(TG_REG, 5'd2, 8'h5a);
        pl(TG_REG, 5'd3, 8'h5b);
        pl(TG_IO, 5'd5, 8'h04);
        pl(TG_FLAG, 5'd0, 8'ha5);
        rom.mem[0] = sk_w[i];
        rom.mem[1] = j ? {OP_LONG, 12'h000} : 16'h0000;
        if (sk_hit[i]) go(16'h0002 + j, 2 + j);
        else go(16'h0001, 1);
        `CHK("skip flags", 8'ha5, flags)
      end
    $display("skip test done");
    // every flag, both senses, backward offset
    for (int v = 0; v < 3; v++)
      for (int f = 0; f < 8; f++)
        for (int p = 0; p < 2; p++)
        begin
          rst(2);
          pl(TG_FLAG, 5'd0, fv[v]);
          rom.mem[0] = {OP_BRANCH, p[0], f[2:0], 8'hfe};
          fl = (f == 4) ? (fv[v][F_N] ^ fv[v][F_V]) : fv[v][f];
          if (fl == p[0]) go(16'hffff, 2);
          else go(16'h0001, 1);
          `CHK("branch flags", fv[v], flags)
        end
    $display("branch test done");
    // jumps, calls and returns
    for (int i = 0; i < 5; i++)
    begin
      rst(2);
      pl(TG_REG, 5'd30, 8'h34);
      pl(TG_REG, 5'd31, 8'h12);
      rom.mem[0] = fw0[i];
      rom.mem[fa1[i]] = fw1[i];
      go(fend[i], fcy[i]);
      `CHK("flow flags", ffl[i], flags)
    end
    $display("flow test done");
    // io bit clear then set
    rst(2);
    pl(TG_IO, 5'd3, 8'ha5);
    rom.mem[0] = {OP_IOBIT, 4'h0, 5'd3, 3'd0};
    rom.mem[1] = {OP_IOBIT, 4'h8, 5'd3, 3'd6};
    go(16'h0002, 4);
    `CHK("io3", 8'he4, ios[3])
    `CHK("io4", 8'h00, ios[4])
    `CHK("iobit flags", 8'h00, flags)
    $display("io bit test done");
    // compares and shifts
    for (int i = 0; i < 11; i++)
    begin
      rst(2);
      pl(TG_FLAG, 5'd0, cf[i]);
      pl(TG_REG, 5'd16, ca[i]);
      pl(TG_REG, 5'd17, cb[i]);
      pl(TG_REG, 5'd20, ca[i]);
      case (kd[i])
        0: rom.mem[0] = {OP_CMP, CM_REGS, 5'd16, 5'd17};
        1: rom.mem[0] = {OP_CMP, CM_CARRY, 5'd16, 5'd17};
        2: rom.mem[0] = {OP_CMPI, 4'h0, cb[i]};
        default: rom.mem[0] = {OP_SHIFT, 2'(kd[i] - 3), 5'd0, 5'd20};
      endcase
      go(16'h0001, 1);
      ef = cf[i];
      if (kd[i] < 3)
      begin
        cin = (kd[i] == 1) & cf[i][F_C];
        d = {1'b0, ca[i]} - {1'b0, cb[i]} - cin;
        hd = {1'b0, ca[i][3:0]} - {1'b0, cb[i][3:0]} - cin;
        ef[F_C] = d[8];
        ef[F_H] = hd[4];
        ef[F_N] = d[7];
        ef[F_V] = (ca[i][7] & ~cb[i][7] & ~d[7]) | (~ca[i][7] & cb[i][7] & d[7]);
        ef[F_Z] = (d[7:0] == 8'h00) & ((kd[i] != 1) | cf[i][F_Z]);
        m = 8'hef;
        er = ca[i];
      end
      else
      begin
        case (kd[i])
          3: {c, r} = {ca[i], 1'b0};
          4: {r, c} = {1'b0, ca[i]};
          5: {c, r} = {ca[i], cf[i][F_C]};
          default: {r, c} = {cf[i][F_C], ca[i]};
        endcase
        ef[F_C] = c;
        ef[F_Z] = (r == 8'h00);
        ef[F_N] = r[7];
        m = 8'he7;
        er = r;
      end
      `CHK("alu flags", ef & m, flags & m)
      `CHK("r20", er, regs[20])
      `CHK("r16", ca[i], regs[16])
    end
    $display("alu test done");
    final_report;
  end
endmodule // test_branch_skip_bit_shift_exec
